// ==== src/cfdf_pkg.sv ====
/*
  Package for the CPU flag and data-format unit: operation codes, sizes,
  condition register bit positions, reset values and carrier structs.
  Assumes a single synchronous clock domain with the core sequencer outside.
*/
package cfdf_pkg;

  // ********************************************
  // Condition register layout
  // ********************************************
  localparam int unsigned CF_I = 7;
  localparam int unsigned CF_UI = 6;
  localparam int unsigned CF_H = 5;
  localparam int unsigned CF_U = 4;
  localparam int unsigned CF_N = 3;
  localparam int unsigned CF_Z = 2;
  localparam int unsigned CF_V = 1;
  localparam int unsigned CF_C = 0;
  localparam int unsigned EXR_T = 7;
  localparam logic [7:0] EXR_RESERVED_ONES = 8'h78;
  localparam logic [2:0] EXR_MASK_RESET = 3'h7;
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam logic [7:0] EXR_RESET = 8'h7F;
  localparam int unsigned MAC_VALID_HIGH_BITS = 10;
  localparam logic [23:0] ADDR_EVEN_MASK = 24'hFFFFFE;

  // ********************************************
  // Types
  // ********************************************
  typedef enum logic [1:0] {CFDF_SZ_BYTE, CFDF_SZ_WORD, CFDF_SZ_LONG} cfdf_size_t;

  typedef enum logic [4:0] {
    CFDF_OP_NONE, CFDF_OP_ADD, CFDF_OP_ADDX, CFDF_OP_SUB, CFDF_OP_SUBX, CFDF_OP_CMP,
    CFDF_OP_NEG, CFDF_OP_AND, CFDF_OP_OR, CFDF_OP_XOR, CFDF_OP_MOV,
    CFDF_OP_SHL, CFDF_OP_SHR, CFDF_OP_SAR, CFDF_OP_ROTL, CFDF_OP_ROTR,
    CFDF_OP_DAA, CFDF_OP_DAS,
    CFDF_OP_BSET, CFDF_OP_BCLR, CFDF_OP_BNOT, CFDF_OP_BTST, CFDF_OP_BLD,
    CFDF_OP_BST, CFDF_OP_BAND, CFDF_OP_BOR, CFDF_OP_BXOR,
    CFDF_OP_MAC, CFDF_OP_CLRMAC, CFDF_OP_PERIPH
  } cfdf_op_t;

  typedef enum logic [2:0] {
    CFDF_CW_NONE, CFDF_CW_LDC, CFDF_CW_AND_CONTROL_INSTR, CFDF_CW_ORC, CFDF_CW_XOR_CONTROL_INSTR
  } cfdf_ctl_op_t;

  typedef struct packed {
    logic valid;
    cfdf_op_t op;
    cfdf_size_t size;
    logic invert;
    logic [2:0] bit_num;
    logic [31:0] a;
    logic [31:0] b;
  } cfdf_alu_req_t;

  typedef struct packed {
    logic valid;
    cfdf_ctl_op_t op;
    logic target_exr;
    logic [7:0] imm;
  } cfdf_ctl_req_t;

  typedef struct packed {
    logic valid;
    logic is_fetch;
    cfdf_size_t size;
    logic [23:0] addr;
  } cfdf_mem_req_t;

  typedef struct packed {
    logic accum_high_half_we;
    logic accum_low_half_we;
    logic [31:0] data;
  } cfdf_mac_wr_t;

  typedef struct packed {
    logic [7:0] condition_flags;
    logic [7:0] extended_control;
    logic [31:0] result;
    logic [9:0] accum_high_half;
    logic [31:0] accum_low_half;
    logic [23:0] pc;
    logic [23:0] mem_addr;
    logic done;
    logic illegal;
  } cfdf_state_t;

endpackage : cfdf_pkg

// ==== src/cfdf_core.sv ====
/*
  Flag and data-format unit of the CPU: condition and extended control
  registers, ALU result flags, bit accumulator, decimal adjust, the
  multiply-accumulate register, reset vector load and address alignment.
  Assumes the sequencer presents one operation per cycle and that memory
  sits behind the aligned address output.
*/
// Operation
// - User bit 4 readable and writable by control-register instructions.
// - Negative flag takes result sign bit at current operand size.
// - Zero flag set when result is all zeros, else cleared.
// - Overflow flag set on signed overflow, cleared otherwise.
// - Carry flag: add carry, subtract borrow, shifted-out bit.
// - Bit instructions use carry as one-bit accumulator.
// - Accumulator is 64 bits; high half keeps ten bits, rest sign.
// - Reset loads PC from vector, clears trace, sets mask bits.
// - Reset leaves other flags and general registers uninitialised.
// - Odd word or longword access forces address bit zero low.
// - Instruction fetches also force address bit zero low.
// - Bit instructions select bit zero to seven of a byte.
// - Decimal adjust treats a byte as two packed digits.
// - Operands of bit, digit, byte, word, longword handled.
// - Peripheral-synchronised byte moves are unsupported.
// - Push and pop behave as stack-pointer moves.
// - Document lists sixty-nine instruction types in eight groups; core decodes 29 operation codes.
// - Half-carry from bit 3, 11 or 27 per size.
`timescale 1ns/1ps
`default_nettype none

module cfdf_core
  import cfdf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reset_vec_valid_i,
  input wire logic [23:0] reset_vec_i,
  input wire cfdf_pkg::cfdf_alu_req_t alu_req_i,
  input wire cfdf_pkg::cfdf_ctl_req_t ctl_req_i,
  input wire cfdf_pkg::cfdf_mem_req_t mem_req_i,
  input wire cfdf_pkg::cfdf_mac_wr_t mac_wr_i,
  input wire logic [31:0] mac_product_i,
  output logic [7:0] condition_flags_o,
  output logic [7:0] extended_control_o,
  output logic [31:0] result_o,
  output logic [31:0] accum_high_half_o,
  output logic [31:0] accum_low_half_o,
  output logic [23:0] pc_o,
  output logic [23:0] mem_addr_o,
  output logic done_o,
  output logic illegal_o
);

  // ********************************************
  // Helpers
  // ********************************************
  function automatic logic [31:0] size_mask(input cfdf_size_t sz);
    case (sz)
      CFDF_SZ_BYTE: size_mask = 32'h000000FF;
      CFDF_SZ_WORD: size_mask = 32'h0000FFFF;
      default: size_mask = 32'hFFFFFFFF;
    endcase
  endfunction : size_mask

  function automatic logic msb_of(input logic [31:0] v, input cfdf_size_t sz);
    case (sz)
      CFDF_SZ_BYTE: msb_of = v[7];
      CFDF_SZ_WORD: msb_of = v[15];
      default: msb_of = v[31];
    endcase
  endfunction : msb_of

  function automatic logic hc_of(input logic [31:0] x, input cfdf_size_t sz);
    case (sz)
      CFDF_SZ_BYTE: hc_of = x[4];
      CFDF_SZ_WORD: hc_of = x[12];
      default: hc_of = x[28];
    endcase
  endfunction : hc_of

  cfdf_state_t st_reg;
  cfdf_state_t st_next;

  // ********************************************
  // Next-state logic
  // ********************************************
  always_comb
  begin
    logic [31:0] m;
    logic [31:0] a;
    logic [31:0] b;
    logic [32:0] sum;
    logic [31:0] carries;
    logic [31:0] r;
    logic cin;
    logic sub;
    logic arith;
    logic logic_op;
    logic shift;
    logic bitop;
    logic sa;
    logic sb;
    logic sr;
    logic c_new;
    logic v_new;
    logic bit_sel;
    logic [7:0] adj;
    logic [63:0] acc;
    logic [7:0] ctl;
    m = 32'h0;
    a = 32'h0;
    b = 32'h0;
    sum = 33'h0;
    carries = 32'h0;
    r = 32'h0;
    cin = 1'b0;
    sub = 1'b0;
    arith = 1'b0;
    logic_op = 1'b0;
    shift = 1'b0;
    bitop = 1'b0;
    sa = 1'b0;
    sb = 1'b0;
    sr = 1'b0;
    c_new = 1'b0;
    v_new = 1'b0;
    bit_sel = 1'b0;
    adj = 8'h00;
    acc = 64'h0;
    ctl = 8'h00;
    st_next = st_reg;
    st_next.done = 1'b0;
    st_next.illegal = 1'b0;

    m = size_mask(alu_req_i.size);
    a = alu_req_i.a & m;
    b = alu_req_i.b & m;
    case (alu_req_i.op)
      CFDF_OP_ADD, CFDF_OP_ADDX: arith = 1'b1;
      CFDF_OP_SUB, CFDF_OP_SUBX, CFDF_OP_CMP, CFDF_OP_NEG:
      begin
        arith = 1'b1;
        sub = 1'b1;
      end
      CFDF_OP_AND, CFDF_OP_OR, CFDF_OP_XOR, CFDF_OP_MOV: logic_op = 1'b1;
      CFDF_OP_SHL, CFDF_OP_SHR, CFDF_OP_SAR, CFDF_OP_ROTL, CFDF_OP_ROTR: shift = 1'b1;
      CFDF_OP_BSET, CFDF_OP_BCLR, CFDF_OP_BNOT, CFDF_OP_BTST, CFDF_OP_BLD,
      CFDF_OP_BST, CFDF_OP_BAND, CFDF_OP_BOR, CFDF_OP_BXOR: bitop = 1'b1;
      default: ;
    endcase
    if (alu_req_i.op == CFDF_OP_NEG)
    begin
      b = a;
      a = 32'h0;
    end
    cin = (alu_req_i.op == CFDF_OP_ADDX || alu_req_i.op == CFDF_OP_SUBX)
      ? st_reg.condition_flags[CF_C] : 1'b0;
    if (sub)
      sum = {1'b0, a} + {1'b0, ~b & m} + {32'h0, ~cin};
    else
      sum = {1'b0, a} + {1'b0, b} + {32'h0, cin};
    carries = sum[31:0] ^ a ^ (sub ? (~b & m) : b);
    sa = msb_of(a, alu_req_i.size);
    sb = msb_of(sub ? ~b : b, alu_req_i.size);

    if (arith)
    begin
      r = sum[31:0] & m;
      sr = msb_of(r, alu_req_i.size);
      c_new = (alu_req_i.size == CFDF_SZ_BYTE) ? carries[8]
        : (alu_req_i.size == CFDF_SZ_WORD) ? carries[16] : sum[32];
      c_new = c_new ^ sub;
      v_new = (sa == sb) && (sr != sa);
    end
    else if (logic_op)
    begin
      case (alu_req_i.op)
        CFDF_OP_AND: r = a & b;
        CFDF_OP_OR: r = a | b;
        CFDF_OP_XOR: r = a ^ b;
        default: r = b;
      endcase
    end
    else if (shift)
    begin
      sr = msb_of(a, alu_req_i.size);
      case (alu_req_i.op)
        CFDF_OP_SHL, CFDF_OP_ROTL:
        begin
          c_new = sr;
          r = ((a << 1) | ((alu_req_i.op == CFDF_OP_ROTL) ? {31'h0, sr} : 32'h0)) & m;
        end
        default:
        begin
          c_new = a[0];
          r = a >> 1;
          if (alu_req_i.op == CFDF_OP_SAR || alu_req_i.op == CFDF_OP_ROTR)
            r = r | ((((alu_req_i.op == CFDF_OP_SAR) ? sr : a[0]) ? ~(m >> 1) : 32'h0) & m);
        end
      endcase
    end
    else
    begin
      r = a;
    end

    if (alu_req_i.op == CFDF_OP_DAA || alu_req_i.op == CFDF_OP_DAS)
    begin
      adj[3:0] = (st_reg.condition_flags[CF_H] || (a[3:0] > 4'h9)) ? 4'h6 : 4'h0;
      c_new = st_reg.condition_flags[CF_C] || (a[7:0] > 8'h99);
      adj[7:4] = c_new ? 4'h6 : 4'h0;
      r = {24'h0, (alu_req_i.op == CFDF_OP_DAA) ? (a[7:0] + adj) : (a[7:0] - adj)};
    end

    bit_sel = a[alu_req_i.bit_num] ^ alu_req_i.invert;
    if (bitop)
    begin
      r = a & 32'hFF;
      case (alu_req_i.op)
        CFDF_OP_BSET: r[alu_req_i.bit_num] = 1'b1;
        CFDF_OP_BCLR: r[alu_req_i.bit_num] = 1'b0;
        CFDF_OP_BNOT: r[alu_req_i.bit_num] = ~a[alu_req_i.bit_num];
        CFDF_OP_BST: r[alu_req_i.bit_num] = st_reg.condition_flags[CF_C] ^ alu_req_i.invert;
        default: ;
      endcase
    end

    if (alu_req_i.valid)
    begin
      st_next.done = 1'b1;
      st_next.result = r;
      // only affected flags change, all in one edge
      if (arith || logic_op || shift || alu_req_i.op == CFDF_OP_DAA
        || alu_req_i.op == CFDF_OP_DAS)
      begin
        st_next.condition_flags[CF_N] = msb_of(r, alu_req_i.size);
        st_next.condition_flags[CF_Z] = ((r & m) == 32'h0);
        if (!(alu_req_i.op == CFDF_OP_DAA || alu_req_i.op == CFDF_OP_DAS))
          st_next.condition_flags[CF_V] = v_new;
        if (!logic_op)
          st_next.condition_flags[CF_C] = c_new;
      end
      // half-carry at 3/11/27
      // Borrow is the inverted carry on subtract
      if (arith)
        st_next.condition_flags[CF_H] = hc_of(carries, alu_req_i.size) ^ sub;
      case (alu_req_i.op)
        CFDF_OP_BTST: st_next.condition_flags[CF_Z] = ~a[alu_req_i.bit_num];
        CFDF_OP_BLD: st_next.condition_flags[CF_C] = bit_sel;
        CFDF_OP_BAND: st_next.condition_flags[CF_C] = st_reg.condition_flags[CF_C] & bit_sel;
        CFDF_OP_BOR: st_next.condition_flags[CF_C] = st_reg.condition_flags[CF_C] | bit_sel;
        CFDF_OP_BXOR: st_next.condition_flags[CF_C] = st_reg.condition_flags[CF_C] ^ bit_sel;
        default: ;
      endcase
      // accumulate, high half keeps ten bits
      acc = {{22{st_reg.accum_high_half[9]}}, st_reg.accum_high_half, st_reg.accum_low_half};
      if (alu_req_i.op == CFDF_OP_MAC)
        acc = acc + {{32{mac_product_i[31]}}, mac_product_i};
      else if (alu_req_i.op == CFDF_OP_CLRMAC)
        acc = 64'h0;
      st_next.accum_high_half = acc[41:32];
      st_next.accum_low_half = acc[31:0];
      if (alu_req_i.op == CFDF_OP_PERIPH)
      begin
        st_next.illegal = 1'b1;
        st_next.done = 1'b0;
      end
    end
    if (mac_wr_i.accum_high_half_we)
      st_next.accum_high_half = mac_wr_i.data[9:0];
    if (mac_wr_i.accum_low_half_we)
      st_next.accum_low_half = mac_wr_i.data;

    if (ctl_req_i.valid)
    begin
      ctl = ctl_req_i.target_exr ? st_reg.extended_control : st_reg.condition_flags;
      case (ctl_req_i.op)
        CFDF_CW_LDC: ctl = ctl_req_i.imm;
        CFDF_CW_AND_CONTROL_INSTR: ctl = ctl & ctl_req_i.imm;
        CFDF_CW_ORC: ctl = ctl | ctl_req_i.imm;
        CFDF_CW_XOR_CONTROL_INSTR: ctl = ctl ^ ctl_req_i.imm;
        default: ;
      endcase
      if (ctl_req_i.target_exr)
        st_next.extended_control = ctl | EXR_RESERVED_ONES;
      else
        st_next.condition_flags = ctl;
      st_next.done = 1'b1;
    end

    // push and pop share this path
    if (mem_req_i.valid)
    begin
      if (mem_req_i.is_fetch || mem_req_i.size != CFDF_SZ_BYTE)
        st_next.mem_addr = mem_req_i.addr & ADDR_EVEN_MASK;
      else
        st_next.mem_addr = mem_req_i.addr;
      if (mem_req_i.is_fetch)
        st_next.pc = mem_req_i.addr & ADDR_EVEN_MASK;
    end

    if (reset_vec_valid_i)
    begin
      st_next.pc = reset_vec_i & ADDR_EVEN_MASK;
      st_next.condition_flags[CF_I] = 1'b1;
      st_next.extended_control[EXR_T] = 1'b0;
      st_next.extended_control[2:0] = EXR_MASK_RESET;
    end
  end

  // ********************************************
  // State register
  // ********************************************
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      // other flags hold no meaning; zero for determinism
      st_reg <= '0;
      st_reg.condition_flags <= CCR_RESET;
      st_reg.extended_control <= EXR_RESET;
    end
    else
      st_reg <= st_next;
  end

  assign condition_flags_o = st_reg.condition_flags;
  assign extended_control_o = st_reg.extended_control;
  assign result_o = st_reg.result;
  assign accum_high_half_o = {{22{st_reg.accum_high_half[9]}}, st_reg.accum_high_half};
  assign accum_low_half_o = st_reg.accum_low_half;
  assign pc_o = st_reg.pc;
  assign mem_addr_o = st_reg.mem_addr;
  assign done_o = st_reg.done;
  assign illegal_o = st_reg.illegal;

endmodule : cfdf_core

`default_nettype wire

// ==== bench/cfdf_core_chk.sv ====
/*
  Port checker for cfdf_core, bound to every instance.
  Assumes one clock domain with a synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module cfdf_core_chk
  import cfdf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reset_vec_valid_i,
  input wire logic [23:0] reset_vec_i,
  input wire cfdf_pkg::cfdf_alu_req_t alu_req_i,
  input wire cfdf_pkg::cfdf_ctl_req_t ctl_req_i,
  input wire cfdf_pkg::cfdf_mem_req_t mem_req_i,
  input wire cfdf_pkg::cfdf_mac_wr_t mac_wr_i,
  input wire logic [31:0] mac_product_i,
  input wire logic [7:0] condition_flags_o,
  input wire logic [7:0] extended_control_o,
  input wire logic [31:0] result_o,
  input wire logic [31:0] accum_high_half_o,
  input wire logic [31:0] accum_low_half_o,
  input wire logic [23:0] pc_o,
  input wire logic [23:0] mem_addr_o,
  input wire logic done_o,
  input wire logic illegal_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ****************
  // Helpers
  // ****************
  logic add_l;
  logic [32:0] sum_l;
  logic ovf_l;
  logic [23:0] exp_addr;
  logic quiet;
  logic [41:0] acc_now;
  logic [41:0] acc_add;
  assign add_l = alu_req_i.valid && alu_req_i.op == CFDF_OP_ADD
    && alu_req_i.size == CFDF_SZ_LONG && !ctl_req_i.valid && !reset_vec_valid_i;
  assign sum_l = {1'b0, alu_req_i.a} + {1'b0, alu_req_i.b};
  assign ovf_l = alu_req_i.a[31] == alu_req_i.b[31] && sum_l[31] != alu_req_i.a[31];
  // Byte data accesses keep the odd address
  assign exp_addr = (mem_req_i.size == CFDF_SZ_BYTE && !mem_req_i.is_fetch)
    ? mem_req_i.addr : (mem_req_i.addr & ADDR_EVEN_MASK);
  assign quiet = !alu_req_i.valid && !ctl_req_i.valid && !reset_vec_valid_i;
  assign acc_now = {accum_high_half_o[9:0], accum_low_half_o};
  assign acc_add = acc_now + {{10{mac_product_i[31]}}, mac_product_i};
  // ****************
  // Assertions
  // ****************
  done_after_req_a: assert property (
    (alu_req_i.valid && alu_req_i.op != CFDF_OP_PERIPH) || ctl_req_i.valid |=> done_o)
    else $error("done missing after request");
  periph_refused_a: assert property (
    alu_req_i.valid && alu_req_i.op == CFDF_OP_PERIPH && !ctl_req_i.valid
    |=> illegal_o && !done_o) else $error("peripheral move not refused");
  sign_zero_a: assert property (add_l |=> condition_flags_o[CF_Z] == (result_o == 32'h0)
    && condition_flags_o[CF_N] == result_o[31]) else $error("sign or zero flag wrong");
  carry_long_a: assert property (add_l |=>
    condition_flags_o[CF_C] == $past(sum_l[32])) else $error("carry flag wrong");
  overflow_long_a: assert property (add_l |=>
    condition_flags_o[CF_V] == $past(ovf_l)) else $error("overflow flag wrong");
  addr_align_a: assert property (mem_req_i.valid |=>
    mem_addr_o == $past(exp_addr)) else $error("address alignment wrong");
  vector_load_a: assert property (reset_vec_valid_i && !mem_req_i.valid |=>
    pc_o == ($past(reset_vec_i) & ADDR_EVEN_MASK) && condition_flags_o[CF_I]
    && !extended_control_o[EXR_T]
    && extended_control_o[2:0] == EXR_MASK_RESET) else $error("reset vector load wrong");
  mac_accum_a: assert property (
    alu_req_i.valid && alu_req_i.op == CFDF_OP_MAC && !mac_wr_i.accum_high_half_we && !mac_wr_i.accum_low_half_we
    |=> acc_now == $past(acc_add) && accum_high_half_o[31:10] == {22{accum_high_half_o[9]}})
    else $error("accumulate wrong");
  flags_hold_a: assert property (quiet |=> $stable(condition_flags_o))
    else $error("flags moved without request");
  user_bit_load_a: assert property (ctl_req_i.valid && ctl_req_i.op == CFDF_CW_LDC
    && !ctl_req_i.target_exr && !reset_vec_valid_i |=> condition_flags_o == $past(ctl_req_i.imm))
    else $error("flag load wrong");
  cover property (add_l ##1 done_o);
  cover property (mem_req_i.valid && mem_req_i.addr[0]);
  cover property (reset_vec_valid_i);
endmodule : cfdf_core_chk
bind cfdf_core cfdf_core_chk i_cfdf_core_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .reset_vec_valid_i(reset_vec_valid_i), .reset_vec_i(reset_vec_i), .alu_req_i(alu_req_i),
  .ctl_req_i(ctl_req_i), .mem_req_i(mem_req_i), .mac_wr_i(mac_wr_i),
  .mac_product_i(mac_product_i), .condition_flags_o(condition_flags_o),
  .extended_control_o(extended_control_o), .result_o(result_o),
  .accum_high_half_o(accum_high_half_o), .accum_low_half_o(accum_low_half_o),
  .pc_o(pc_o), .mem_addr_o(mem_addr_o),
  .done_o(done_o), .illegal_o(illegal_o));
`default_nettype wire

// ==== bench/cfdf_mem_model.sv ====
/*
  Memory model: 32 bytes answering the presented address with a word.
  Assumes the address comes from the unit's registered address output.
*/
`timescale 1ns/1ps
`default_nettype none
module cfdf_mem_model (
  input wire logic [23:0] addr_i,
  output logic [15:0] rd_word_o
);
  logic [7:0] mem [0:31];
  initial
  begin
    for (int i = 0; i < 32; i++)
      mem[i] = 8'h10 + 8'(i);
  end
  // No alignment here, so a misaligned address shows in the data
  assign rd_word_o = {mem[addr_i[4:0]], mem[addr_i[4:0] + 5'h1]};
endmodule : cfdf_mem_model
`default_nettype wire

// ==== bench/test_cfdf_core.sv ====
/*
  Testbench for cfdf_core with a memory model on its address output.
  Assumes the package, design, checker and model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_cfdf_core;
  import cfdf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic vec_v = 1'b0;
  logic [23:0] vec = 24'h0;
  cfdf_alu_req_t alu = '0;
  cfdf_ctl_req_t ctl = '0;
  cfdf_mem_req_t mreq = '0;
  cfdf_mac_wr_t macw = '0;
  logic [31:0] prod = 32'h0;
  logic [7:0] condition_flags;
  logic [7:0] extended_control;
  logic [31:0] res;
  logic [31:0] accum_high_half;
  logic [31:0] accum_low_half;
  logic [23:0] pc;
  logic [23:0] maddr;
  logic done;
  logic ill;
  logic [15:0] word;
  int bad_count = 0;
  int cmp_count = 0;
  cfdf_core i_cfdf_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .reset_vec_valid_i(vec_v),
    .reset_vec_i(vec), .alu_req_i(alu), .ctl_req_i(ctl), .mem_req_i(mreq), .mac_wr_i(macw),
    .mac_product_i(prod), .condition_flags_o(condition_flags), .extended_control_o(extended_control), .result_o(res),
    .accum_high_half_o(accum_high_half), .accum_low_half_o(accum_low_half), .pc_o(pc), .mem_addr_o(maddr),
    .done_o(done), .illegal_o(ill));
  cfdf_mem_model i_cfdf_mem_model (.addr_i(maddr), .rd_word_o(word));
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  // ****************
  // Shared tasks
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
      begin
        bad_count++;
        $display("CHECK FAILED %0t %s got %h want %h", $time, what, seen, exp);
      end
  endtask : check
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic ctl_op(input cfdf_ctl_op_t op, input logic tx, input logic [7:0] imm);
    @(negedge clk_i);
    ctl = '{valid: 1'b1, op: op, target_exr: tx, imm: imm};
    @(negedge clk_i);
    ctl = '0;
    check(done, 1'b1, "ctl done");
  endtask : ctl_op
  task automatic alu_chk(input cfdf_op_t op, input cfdf_size_t sz, input logic [31:0] a,
      input logic [31:0] b, input logic [31:0] r, input logic [7:0] m, input logic [7:0] f,
      input logic [2:0] bn = 3'h0, input logic cr = 1'b1);
    @(negedge clk_i);
    alu = '{valid: 1'b1, op: op, size: sz, invert: 1'b0, bit_num: bn, a: a, b: b};
    @(negedge clk_i);
    alu = '0;
    check(done, 1'b1, "alu done");
    if (cr)
      check(res, r, "result");
    check(condition_flags & m, f, "flags");
  endtask : alu_chk
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset_init();
    // stack pointer setup is left to software; nothing here waits on it
    check(condition_flags, CCR_RESET, "ccr reset");
    check(extended_control, EXR_RESET, "exr reset");
    ctl_op(CFDF_CW_LDC, 1'b0, 8'h00);
    ctl_op(CFDF_CW_LDC, 1'b1, 8'h80);
    check(extended_control, 8'hF8, "exr load");
    @(negedge clk_i);
    vec_v = 1'b1;
    vec = 24'h012344;
    @(negedge clk_i);
    vec_v = 1'b0;
    check(pc, 24'h012344, "pc vector");
    check(condition_flags, 8'h80, "ccr mask");
    check(extended_control, 8'h7F, "exr trace");
    $display("test reset_init done");
  endtask : t_reset_init
  task automatic t_user_bit();
    ctl_op(CFDF_CW_LDC, 1'b0, 8'h10);
    check(condition_flags, 8'h10, "ldc");
    ctl_op(CFDF_CW_AND_CONTROL_INSTR, 1'b0, 8'hEF);
    check(condition_flags, 8'h00, "and_control_instr");
    ctl_op(CFDF_CW_ORC, 1'b0, 8'h10);
    check(condition_flags, 8'h10, "orc");
    ctl_op(CFDF_CW_XOR_CONTROL_INSTR, 1'b0, 8'h10);
    check(condition_flags, 8'h00, "xor_control_instr");
    $display("test user_bit done");
  endtask : t_user_bit
  task automatic t_arith();
    // User bit set first; arithmetic must leave it alone
    ctl_op(CFDF_CW_LDC, 1'b0, 8'h10);
    alu_chk(CFDF_OP_ADD, CFDF_SZ_BYTE, 32'hFF, 32'h1, 32'h0, 8'h3F, 8'h35);
    alu_chk(CFDF_OP_ADD, CFDF_SZ_BYTE, 32'h7F, 32'h1, 32'h80, 8'h3F, 8'h3A);
    alu_chk(CFDF_OP_ADD, CFDF_SZ_WORD, 32'hFFF, 32'h1, 32'h1000, 8'h3F, 8'h30);
    alu_chk(CFDF_OP_ADD, CFDF_SZ_LONG, 32'h80000000, 32'h80000000, 32'h0, 8'h3F, 8'h17);
    alu_chk(CFDF_OP_SUB, CFDF_SZ_BYTE, 32'h0, 32'h1, 32'hFF, 8'h3F, 8'h39);
    alu_chk(CFDF_OP_SHL, CFDF_SZ_BYTE, 32'h81, 32'h0, 32'h2, 8'h11, 8'h11);
    alu_chk(CFDF_OP_SAR, CFDF_SZ_BYTE, 32'h81, 32'h0, 32'hC0, 8'h09, 8'h09);
    alu_chk(CFDF_OP_AND, CFDF_SZ_WORD, 32'h1234F0F0, 32'hF0F, 32'h0, 8'h0E, 8'h04);
    alu_chk(CFDF_OP_ADD, CFDF_SZ_BYTE, 32'h19, 32'h28, 32'h41, 8'h21, 8'h20);
    alu_chk(CFDF_OP_DAA, CFDF_SZ_BYTE, 32'h41, 32'h0, 32'h47, 8'h0D, 8'h00);
    $display("test arith done");
  endtask : t_arith
  task automatic t_bits();
    ctl_op(CFDF_CW_AND_CONTROL_INSTR, 1'b0, 8'hFE);
    alu_chk(CFDF_OP_BLD, CFDF_SZ_BYTE, 32'h80, 32'h0, 32'h0, 8'h1, 8'h1, 3'h7, 1'b0);
    alu_chk(CFDF_OP_BAND, CFDF_SZ_BYTE, 32'h80, 32'h0, 32'h0, 8'h1, 8'h0, 3'h6, 1'b0);
    alu_chk(CFDF_OP_BOR, CFDF_SZ_BYTE, 32'h80, 32'h0, 32'h0, 8'h1, 8'h1, 3'h7, 1'b0);
    alu_chk(CFDF_OP_BXOR, CFDF_SZ_BYTE, 32'h80, 32'h0, 32'h0, 8'h1, 8'h0, 3'h7, 1'b0);
    alu_chk(CFDF_OP_BST, CFDF_SZ_BYTE, 32'hFF, 32'h0, 32'hFE, 8'h1, 8'h0, 3'h0);
    alu_chk(CFDF_OP_BTST, CFDF_SZ_BYTE, 32'h4, 32'h0, 32'h0, 8'h4, 8'h0, 3'h2, 1'b0);
    alu_chk(CFDF_OP_BTST, CFDF_SZ_BYTE, 32'h4, 32'h0, 32'h0, 8'h4, 8'h4, 3'h3, 1'b0);
    alu_chk(CFDF_OP_BSET, CFDF_SZ_BYTE, 32'h0, 32'h0, 32'h80, 8'h0, 8'h0, 3'h7);
    alu_chk(CFDF_OP_BCLR, CFDF_SZ_BYTE, 32'hFF, 32'h0, 32'hEF, 8'h0, 8'h0, 3'h4);
    alu_chk(CFDF_OP_BNOT, CFDF_SZ_BYTE, 32'hF, 32'h0, 32'hE, 8'h0, 8'h0, 3'h0);
    $display("test bits done");
  endtask : t_bits
  task automatic t_mac();
    @(negedge clk_i);
    macw = '{accum_high_half_we: 1'b1, accum_low_half_we: 1'b1, data: 32'h00000200};
    @(negedge clk_i);
    macw = '0;
    check(accum_high_half, 32'hFFFFFE00, "accum_high_half sign");
    check(accum_low_half, 32'h00000200, "accum_low_half");
    alu_chk(CFDF_OP_CLRMAC, CFDF_SZ_LONG, 32'h0, 32'h0, 32'h0, 8'h0, 8'h0, 3'h0, 1'b0);
    check(accum_high_half | accum_low_half, 32'h0, "clear");
    prod = 32'hFFFFFFFF;
    alu_chk(CFDF_OP_MAC, CFDF_SZ_LONG, 32'h0, 32'h0, 32'h0, 8'h0, 8'h0, 3'h0, 1'b0);
    check(accum_high_half & accum_low_half, 32'hFFFFFFFF, "mac neg");
    $display("test mac done");
  endtask : t_mac
  task automatic t_align();
    // stack-style word and longword accesses among these
    // no test-and-set here; its register limit stays with software
    for (int k = 0; k < 4; k++)
      begin
        @(negedge clk_i);
        mreq = '{valid: 1'b1, is_fetch: k == 3, size: cfdf_size_t'(2'(k % 3)), addr: 24'h012345};
        @(negedge clk_i);
        mreq = '0;
        check(maddr, k == 0 ? 24'h012345 : 24'h012344, "addr");
        check(word, k == 0 ? 16'h1516 : 16'h1415, "data");
      end
    check(pc, 24'h012344, "fetch pc");
    $display("test align done");
  endtask : t_align
  task automatic t_illegal();
    logic [7:0] c0;
    c0 = condition_flags;
    @(negedge clk_i);
    alu = '{valid: 1'b1, op: CFDF_OP_PERIPH, size: CFDF_SZ_BYTE, default: '0};
    @(negedge clk_i);
    alu = '0;
    check({ill, done}, 2'b10, "refused");
    check(condition_flags, c0, "flags kept");
    $display("test illegal done");
  endtask : t_illegal
  initial
  begin
    repeat (6) @(negedge clk_i);
    rst_n_i = 1'b1;
    t_reset_init();
    t_user_bit();
    t_arith();
    t_bits();
    t_mac();
    t_align();
    t_illegal();
    tally_and_finish();
  end
  initial
  begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    $display("CHECK FAILED %0t watchdog", $time);
    tally_and_finish();
  end
endmodule : test_cfdf_core
`default_nettype wire
